// ---- pkg/dcsr_pkg.sv ----
// shared types and constants for the data cache snoop response block
package dcsr_pkg;
  localparam int ADDR_W = 32;
  localparam int LINE_LSB = 5;
  localparam int LINE_W = ADDR_W - LINE_LSB;
  // transfer_type_field codes
  localparam logic [4:0] TT_CLEAN = 5'h00;
  localparam logic [4:0] TT_FLUSH = 5'h04;
  localparam logic [4:0] TT_SYNC = 5'h08;
  localparam logic [4:0] TT_KILL = 5'h0C;
  localparam logic [4:0] TT_WRITE_FLUSH = 5'h02;
  localparam logic [4:0] TT_WRITE_KILL = 5'h06;
  localparam logic [4:0] TT_READ = 5'h0A;
  localparam logic [4:0] TT_READ_INTENT_MODIFY = 5'h0E;
  localparam logic [4:0] TT_TLB_INV = 5'h18;
  localparam logic [4:0] TT_WRITE_FLUSH_ATOMIC = 5'h12;
  localparam logic [4:0] TT_READ_ATOMIC = 5'h1A;
  localparam logic [4:0] TT_READ_INTENT_MODIFY_ATOMIC = 5'h1E;
  localparam logic [4:0] TT_RESET = TT_SYNC;
  typedef enum logic [1:0] {MEI_I = 2'b00, MEI_E = 2'b01, MEI_M = 2'b10} dcsr_mei_t;
  typedef enum logic [2:0] {
    REQ_LOAD = 3'b000,
    REQ_STORE = 3'b001,
    REQ_LOAD_RESV = 3'b010,
    REQ_STORE_COND = 3'b011,
    REQ_ZERO_GLOBAL = 3'b100
  } dcsr_req_t;
  typedef struct packed {
    logic valid;
    logic [4:0] tt;
    logic [ADDR_W-1:0] addr;
    logic global_snoop_qualifier;
    logic inhibit;
    logic burst;
  } dcsr_snoop_t;
  typedef struct packed {
    logic change;
    dcsr_mei_t next_state;
    logic push;
    logic retry_m;
    logic cancel_resv;
  } dcsr_action_t;
  typedef struct packed {
    logic valid;
    dcsr_mei_t state;
    logic [LINE_W-1:0] line;
    logic push;
    logic hiprio;
    logic cancel_resv;
  } dcsr_update_t;
endpackage

// ---- logic/dcsr_tt_decode.sv ----
// transfer type decode into a cache state action
`timescale 1ns/1ns
`default_nettype none
module dcsr_tt_decode (
  // snoop and current line state
  input wire dcsr_pkg::dcsr_snoop_t snoop,
  input wire dcsr_pkg::dcsr_mei_t tag_state,
  // resulting action
  output var dcsr_pkg::dcsr_action_t act
);
  import dcsr_pkg::*;
  logic hit;
  logic is_mod;
  assign hit = (tag_state != MEI_I);
  assign is_mod = (tag_state == MEI_M);
  always_comb
  begin
    act = '0;
    act.next_state = tag_state;
    case (snoop.tt)
      TT_KILL:
      begin
        act.change = hit;
        act.next_state = MEI_I;
        act.push = is_mod;
        act.cancel_resv = hit;
      end
      TT_WRITE_KILL:
      begin
        // modified data is dropped, never written back
        act.change = hit;
        act.next_state = MEI_I;
        act.cancel_resv = hit;
      end
      TT_READ, TT_READ_ATOMIC:
      begin
        if (snoop.inhibit)
        begin
          act.change = is_mod;
          act.next_state = MEI_E;
          act.push = is_mod;
          act.retry_m = 1'b1;
        end
        else if (snoop.burst || snoop.global_snoop_qualifier)
        begin
          act.change = hit;
          act.next_state = MEI_I;
          act.push = is_mod;
          act.retry_m = 1'b1;
        end
      end
      TT_READ_INTENT_MODIFY, TT_READ_INTENT_MODIFY_ATOMIC:
      begin
        // exclusive line goes invalid directly, with no push and no retry
        act.change = hit;
        act.next_state = MEI_I;
        act.push = is_mod;
        act.retry_m = 1'b1;
      end
      TT_WRITE_FLUSH, TT_WRITE_FLUSH_ATOMIC:
      begin
        act.change = hit;
        act.next_state = MEI_I;
        act.push = is_mod;
        act.retry_m = 1'b1;
      end
      default:
      begin
        act.change = 1'b0;
      end
    endcase
  end
endmodule
`default_nettype wire

// ---- logic/dcsr_tag_busy.sv ----
// tracks cycles in which the cache tags cannot serve a snoop
`timescale 1ns/1ns
`default_nettype none
module dcsr_tag_busy (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill and load progress
  input wire logic transfer_ack,
  input wire logic fill_last_ack,
  input wire logic burst_load,
  input wire logic data_retry_en,
  // own tag updates
  input wire logic op_first,
  input wire logic op_last,
  input wire logic blk_tag_upd,
  // busy indications
  output logic busy_any,
  output logic busy_hit
);
  logic last_ack_d;
  logic committed;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      last_ack_d <= 1'b0;
    else
      last_ack_d <= fill_last_ack;
  end
  // once the first beat lands the tag write cannot be undone
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      committed <= 1'b0;
    else if (fill_last_ack || !burst_load)
      committed <= 1'b0;
    else if (transfer_ack)
      committed <= 1'b1;
  end
  assign busy_hit = committed;
  assign busy_any = op_first || op_last || blk_tag_upd
    || (data_retry_en ? last_ack_d : fill_last_ack);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_data_retry_delay;
    data_retry_en && fill_last_ack |=> busy_any;
  endproperty
  a_data_retry_delay: assert property (p_data_retry_delay) else $error("tags not busy after last ack");
  property p_commit_hold;
    burst_load && transfer_ack && !fill_last_ack ##1 burst_load && !fill_last_ack |-> busy_hit;
  endproperty
  a_commit_hold: assert property (p_commit_hold) else $error("burst load tags not held");
endmodule
`default_nettype wire

// ---- logic/dcsr_snoop_resp.sv ----
// data cache snoop response: retry, state update, push and bus issue
`timescale 1ns/1ns
`default_nettype none
module dcsr_snoop_resp (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // snooped address tenure and tag lookup result
  input wire dcsr_pkg::dcsr_snoop_t snoop,
  input wire dcsr_pkg::dcsr_mei_t tag_state,
  // cast-out buffer
  input wire logic castout_valid,
  input wire logic [dcsr_pkg::LINE_W-1:0] castout_line,
  // line fill progress
  input wire logic transfer_ack,
  input wire logic fill_last_ack,
  input wire logic burst_load,
  input wire logic data_retry_en,
  // own tag-updating operations
  input wire logic op_first,
  input wire logic op_last,
  input wire logic blk_tag_upd,
  // own outstanding read
  input wire logic rd_addr_done,
  input wire logic [dcsr_pkg::ADDR_W-1:0] rd_addr,
  input wire logic rd_data_done,
  // own bus requests
  input wire logic req_valid,
  input wire dcsr_pkg::dcsr_req_t req_kind,
  input wire logic [dcsr_pkg::ADDR_W-1:0] req_addr,
  output logic bus_req_valid,
  output logic [4:0] bus_req_tt,
  output logic [dcsr_pkg::ADDR_W-1:0] bus_req_addr,
  output logic bus_req_addr_only,
  // data bus grant
  input wire logic data_grant,
  input wire logic write_only_data_qualifier,
  input wire logic store_pipelined,
  output logic tenure_store,
  output logic tenure_load,
  // snoop answer
  output logic address_retry,
  output var dcsr_pkg::dcsr_update_t upd
);
  import dcsr_pkg::*;

  logic [LINE_W-1:0] snp_line;
  logic [LINE_W-1:0] rd_line;
  dcsr_action_t act;
  dcsr_update_t next_upd;
  logic busy_any;
  logic busy_hit;
  logic hit;
  logic is_mod;
  logic co_hit;
  logic rd_pending;
  logic rd_match;
  logic blocked;
  logic next_retry;
  logic next_req_valid;

  assign snp_line = snoop.addr[ADDR_W-1:LINE_LSB];
  assign hit = (tag_state != MEI_I);
  assign is_mod = (tag_state == MEI_M);

  dcsr_tt_decode u_decode (
    .snoop(snoop),
    .tag_state(tag_state),
    .act(act)
  );

  dcsr_tag_busy u_busy (
    .clk(clk),
    .rst_b(rst_b),
    .transfer_ack(transfer_ack),
    .fill_last_ack(fill_last_ack),
    .burst_load(burst_load),
    .data_retry_en(data_retry_en),
    .op_first(op_first),
    .op_last(op_last),
    .blk_tag_upd(blk_tag_upd),
    .busy_any(busy_any),
    .busy_hit(busy_hit)
  );

  // the cast-out copy is the only current one, so never let it be read past
  assign co_hit = castout_valid && (castout_line == snp_line);
  assign rd_match = rd_pending && (rd_line == snp_line);

  // a blocked snoop leaves the tags alone; the master comes back later
  assign blocked = busy_any || (busy_hit && hit) || co_hit || rd_match;

  always_comb
  begin
    next_retry = 1'b0;
    if (snoop.valid)
    begin
      // kill-type snoops clear act.retry_m, so an M kill is retried only when blocked
      next_retry = blocked || (act.retry_m && is_mod);
    end
  end

  // a miss in tags and cast-out buffer leaves act.change low
  always_comb
  begin
    next_upd = '0;
    next_upd.line = snp_line;
    next_upd.state = act.next_state;
    if (snoop.valid && !blocked && act.change)
    begin
      next_upd.valid = 1'b1;
      next_upd.push = act.push;
      next_upd.cancel_resv = act.cancel_resv;
      // push may nest inside our own read tenures
      next_upd.hiprio = act.push && rd_pending;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      address_retry <= 1'b0;
    else
      address_retry <= next_retry;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      upd <= '0;
    else
      upd <= next_upd;
  end

  // outstanding read: address tenure done, data tenure still open
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_pending <= 1'b0;
    else if (rd_data_done)
      rd_pending <= 1'b0;
    else if (rd_addr_done)
      rd_pending <= 1'b1;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_line <= '0;
    else if (rd_addr_done)
      rd_line <= rd_addr[ADDR_W-1:LINE_LSB];
  end

  assign next_req_valid = req_valid;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      bus_req_valid <= 1'b0;
    else
      bus_req_valid <= next_req_valid;
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bus_req_tt <= TT_RESET;
      bus_req_addr <= '0;
      bus_req_addr_only <= 1'b0;
    end
    else if (req_valid)
    begin
      bus_req_addr <= req_addr;
      bus_req_addr_only <= (req_kind == REQ_ZERO_GLOBAL);
      unique case (req_kind)
        REQ_LOAD: bus_req_tt <= TT_READ;
        REQ_STORE: bus_req_tt <= TT_READ_INTENT_MODIFY;
        REQ_LOAD_RESV: bus_req_tt <= TT_READ_ATOMIC;
        REQ_STORE_COND: bus_req_tt <= TT_READ_INTENT_MODIFY_ATOMIC;
        REQ_ZERO_GLOBAL: bus_req_tt <= TT_KILL;
      endcase
    end
  end

  // write-only qualifier steals the granted tenure for the pipelined store
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tenure_store <= 1'b0;
      tenure_load <= 1'b0;
    end
    else
    begin
      tenure_store <= data_grant && write_only_data_qualifier && store_pipelined;
      tenure_load <= data_grant && !(write_only_data_qualifier && store_pipelined);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_clear_snoop;
    snoop.valid && !blocked;
  endsequence

  sequence s_mod_hit(logic [4:0] code);
    s_clear_snoop and (snoop.tt == code && is_mod);
  endsequence

  property p_kill_no_retry;
    s_mod_hit(TT_KILL) |=> !address_retry && upd.valid && upd.push && upd.state == MEI_I && upd.cancel_resv;
  endproperty
  a_kill_no_retry: assert property (p_kill_no_retry) else $error("kill on modified line wrong");

  property p_wkill;
    s_clear_snoop and (snoop.tt == TT_WRITE_KILL && hit)
      |=> upd.valid && upd.state == MEI_I && !upd.push && upd.cancel_resv;
  endproperty
  a_wkill: assert property (p_wkill) else $error("write-with-kill not invalidated");

  property p_castout;
    snoop.valid && co_hit |=> address_retry && !upd.valid;
  endproperty
  a_castout: assert property (p_castout) else $error("cast-out hit not retried");

  property p_miss;
    s_clear_snoop and (!hit) |=> !address_retry && !upd.valid;
  endproperty
  a_miss: assert property (p_miss) else $error("miss changed state or retried");

  property p_inhibit_read;
    s_mod_hit(TT_READ) and snoop.inhibit |=> address_retry && upd.push && upd.state == MEI_E;
  endproperty
  a_inhibit_read: assert property (p_inhibit_read) else $error("inhibited read on M wrong");

  property p_burst_read;
    s_mod_hit(TT_READ) and (snoop.burst && !snoop.inhibit)
      |=> address_retry && upd.push && upd.state == MEI_I;
  endproperty
  a_burst_read: assert property (p_burst_read) else $error("burst read not flushed");

  property p_read_intent_modify_excl;
    s_clear_snoop and (snoop.tt == TT_READ_INTENT_MODIFY_ATOMIC && tag_state == MEI_E)
      |=> upd.valid && upd.state == MEI_I && !upd.push && !address_retry;
  endproperty
  a_read_intent_modify_excl: assert property (p_read_intent_modify_excl) else $error("atomic intent-modify on E wrong");

  property p_rd_match;
    rd_pending && !rd_data_done ##0 snoop.valid && rd_line == snp_line |=> address_retry;
  endproperty
  a_rd_match: assert property (p_rd_match) else $error("own read address not retried");

  property p_hiprio;
    s_clear_snoop and (rd_pending && act.push) |=> upd.push && upd.hiprio;
  endproperty
  a_hiprio: assert property (p_hiprio) else $error("push not high priority");

  property p_zero_issue;
    req_valid && req_kind == REQ_ZERO_GLOBAL |=> bus_req_valid && bus_req_tt == TT_KILL && bus_req_addr_only;
  endproperty
  a_zero_issue: assert property (p_zero_issue) else $error("kill-block not issued");

  property p_tenure;
    data_grant && write_only_data_qualifier && store_pipelined |=> tenure_store && !tenure_load;
  endproperty
  a_tenure: assert property (p_tenure) else $error("tenure not given to store");

  property p_nodrtry;
    snoop.valid && !data_retry_en && fill_last_ack |=> address_retry && !upd.valid;
  endproperty
  a_nodrtry: assert property (p_nodrtry) else $error("snoop at last ack not retried");

  property p_op_edges;
    snoop.valid && (op_first || op_last || blk_tag_upd) |=> address_retry;
  endproperty
  a_op_edges: assert property (p_op_edges) else $error("snoop during tag update not retried");

  property p_kill_excl;
    s_clear_snoop and (snoop.tt == TT_KILL && tag_state == MEI_E)
      |=> upd.valid && !upd.push && upd.state == MEI_I && upd.cancel_resv && !address_retry;
  endproperty
  a_kill_excl: assert property (p_kill_excl) else $error("kill on exclusive line wrong");

  property p_gbl_read;
    s_mod_hit(TT_READ) and (snoop.global_snoop_qualifier && !snoop.inhibit) |=> address_retry && upd.push && upd.state == MEI_I;
  endproperty
  a_gbl_read: assert property (p_gbl_read) else $error("global read on M not flushed");

  property p_read_atomic;
    s_mod_hit(TT_READ_ATOMIC) and (snoop.global_snoop_qualifier && !snoop.inhibit) |=> address_retry && upd.push && upd.state == MEI_I;
  endproperty
  a_read_atomic: assert property (p_read_atomic) else $error("read-atomic differs from read");

  property p_read_intent_modify_mod;
    s_mod_hit(TT_READ_INTENT_MODIFY) |=> address_retry && upd.valid && upd.push && upd.state == MEI_I;
  endproperty
  a_read_intent_modify_mod: assert property (p_read_intent_modify_mod) else $error("intent-modify on M not flushed");

  property p_wflush_mod;
    s_mod_hit(TT_WRITE_FLUSH) |=> address_retry && upd.valid && upd.push && upd.state == MEI_I;
  endproperty
  a_wflush_mod: assert property (p_wflush_mod) else $error("write-with-flush on M wrong");

  property p_data_retry_late;
    snoop.valid && data_retry_en && $past(fill_last_ack) |=> address_retry && !upd.valid;
  endproperty
  a_data_retry_late: assert property (p_data_retry_late) else $error("snoop after last ack not retried");

  property p_commit_hit;
    snoop.valid && busy_hit && hit |=> address_retry && !upd.valid;
  endproperty
  a_commit_hit: assert property (p_commit_hit) else $error("hit during burst load not retried");

  property p_blk_upd;
    snoop.valid && blk_tag_upd |=> address_retry && !upd.valid;
  endproperty
  a_blk_upd: assert property (p_blk_upd) else $error("snoop during block tag update not retried");
endmodule
`default_nettype wire

// ---- bench/dcsr_far_end.sv ----
// far-end model: other bus masters with their tag view, and the data bus arbiter
`timescale 1ns/1ns
`default_nettype none
module dcsr_far_end (
  // snooped address tenure
  output var dcsr_pkg::dcsr_snoop_t snoop,
  output var dcsr_pkg::dcsr_mei_t tag_state,
  // data bus arbiter
  output logic data_grant,
  output logic write_only_data_qualifier
);
  import dcsr_pkg::*;
  initial
  begin
    snoop = '0;
    tag_state = MEI_I;
    data_grant = 1'b0;
    write_only_data_qualifier = 1'b0;
  end
  task automatic drive(input logic [4:0] tt, input logic [ADDR_W-1:0] a, input logic g, i, b, input dcsr_mei_t st);
    snoop = '{valid: 1'b1, tt: tt, addr: a, global_snoop_qualifier: g, inhibit: i, burst: b};
    tag_state = st;
  endtask
  // a released bus shows the inverse of its last address and type; the qualifier bits keep their values
  task automatic release_bus();
    snoop.valid = 1'b0;
    snoop.addr = ~snoop.addr;
    snoop.tt = ~snoop.tt;
    tag_state = MEI_I;
  endtask
  // qualifier only ever rides with a grant
  task automatic grant(input logic g, input logic wo);
    data_grant = g;
    write_only_data_qualifier = g & wo;
  endtask
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// self-checking testbench for the snoop response block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dcsr_pkg::*;
  localparam logic [31:0] A = 32'h0000_1040;
  localparam logic [31:0] B = 32'h0000_2080;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic castout_valid = 1'b0, transfer_ack = 1'b0, fill_last_ack = 1'b0, burst_load = 1'b0;
  logic data_retry_en = 1'b0, op_first = 1'b0, op_last = 1'b0, blk_tag_upd = 1'b0;
  logic rd_addr_done = 1'b0, rd_data_done = 1'b0, req_valid = 1'b0, store_pipelined = 1'b0;
  logic [LINE_W-1:0] castout_line = '0;
  logic [31:0] rd_addr = '0, req_addr = '0, bus_req_addr;
  dcsr_req_t req_kind = REQ_LOAD;
  logic bus_req_valid, bus_req_addr_only, tenure_store, tenure_load, address_retry;
  logic data_grant, write_only_data_qualifier;
  logic [4:0] bus_req_tt;
  dcsr_snoop_t snoop;
  dcsr_mei_t tag_state;
  dcsr_update_t upd;
  int n_fail = 0, compares = 0, cycles = 0;
  dcsr_far_end far (.snoop(snoop), .tag_state(tag_state), .data_grant(data_grant),
    .write_only_data_qualifier(write_only_data_qualifier));
  dcsr_snoop_resp dcsr_snoop_resp_inst (.clk(clk), .rst_b(rst_b), .snoop(snoop), .tag_state(tag_state),
    .castout_valid(castout_valid), .castout_line(castout_line), .transfer_ack(transfer_ack),
    .fill_last_ack(fill_last_ack), .burst_load(burst_load), .data_retry_en(data_retry_en),
    .op_first(op_first), .op_last(op_last), .blk_tag_upd(blk_tag_upd), .rd_addr_done(rd_addr_done),
    .rd_addr(rd_addr), .rd_data_done(rd_data_done), .req_valid(req_valid), .req_kind(req_kind),
    .req_addr(req_addr), .bus_req_valid(bus_req_valid), .bus_req_tt(bus_req_tt), .bus_req_addr(bus_req_addr),
    .bus_req_addr_only(bus_req_addr_only), .data_grant(data_grant),
    .write_only_data_qualifier(write_only_data_qualifier), .store_pipelined(store_pipelined),
    .tenure_store(tenure_store), .tenure_load(tenure_load), .address_retry(address_retry), .upd(upd));
  initial
  begin
    forever #2 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
    begin
      $display("All tests passed");
    end
    else
    begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      n_fail++;
      report_and_stop();
    end
  end
  // masked compare: fields the answer leaves open are not judged
  task automatic chk_ans(input logic [33:0] got, input logic [33:0] exp, input logic [33:0] m);
    compares++;
    if ((got & m) !== (exp & m))
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got & m, exp & m);
    end
  endtask
  task automatic chk_req(input logic [38:0] got, input logic [38:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_ten(input logic [1:0] got, input logic [1:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one snoop tenure; answer looked at in the single cycle it stands
  task automatic snp(input logic [4:0] tt, input logic [31:0] a, input logic g, i, b, input dcsr_mei_t st,
    input logic r, v, input dcsr_mei_t ns, input logic p, c, cm, hp);
    logic [33:0] m;
    m = v ? {31'h7FFFFFFF, 1'b1, 1'b1, cm} : {2'h3, 32'h0};
    far.drive(tt, a, g, i, b, st);
    @(negedge clk);
    chk_ans({address_retry, upd}, {r, v, ns, a[31:5], p, hp, c}, m);
    // idle cycle so the bus is never driven twice in one step
    far.release_bus();
    @(negedge clk);
  endtask
  task automatic t_table();
    snp(TT_KILL, A, 0, 0, 0, MEI_M, 0, 1, MEI_I, 1, 1, 1, 0);
    snp(TT_KILL, A, 0, 0, 0, MEI_E, 0, 1, MEI_I, 0, 1, 1, 0);
    snp(TT_WRITE_KILL, A, 0, 0, 0, MEI_M, 0, 1, MEI_I, 0, 1, 1, 0);
    snp(TT_READ, A, 0, 0, 1, MEI_E, 0, 1, MEI_I, 0, 0, 0, 0);
    snp(TT_READ, A, 1, 0, 0, MEI_I, 0, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_READ, A, 1, 0, 0, MEI_M, 1, 1, MEI_I, 1, 0, 0, 0);
    snp(TT_READ, B, 0, 1, 0, MEI_M, 1, 1, MEI_E, 1, 0, 0, 0);
    snp(TT_READ_ATOMIC, A, 1, 0, 0, MEI_M, 1, 1, MEI_I, 1, 0, 0, 0);
    snp(TT_READ_INTENT_MODIFY, B, 0, 0, 0, MEI_E, 0, 1, MEI_I, 0, 0, 0, 0);
    snp(TT_READ_INTENT_MODIFY_ATOMIC, A, 0, 0, 0, MEI_M, 1, 1, MEI_I, 1, 0, 0, 0);
    snp(TT_WRITE_FLUSH, A, 0, 0, 0, MEI_M, 1, 1, MEI_I, 1, 0, 0, 0);
    snp(TT_WRITE_FLUSH_ATOMIC, B, 0, 0, 0, MEI_E, 0, 1, MEI_I, 0, 0, 0, 0);
    snp(TT_SYNC, A, 0, 0, 0, MEI_M, 0, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_TLB_INV, A, 0, 0, 0, MEI_M, 0, 0, MEI_I, 0, 0, 0, 0);
  endtask
  task automatic t_castout();
    castout_valid = 1'b1;
    castout_line = A[31:5];
    snp(TT_READ, A, 1, 0, 0, MEI_I, 1, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_READ, B, 1, 0, 0, MEI_I, 0, 0, MEI_I, 0, 0, 0, 0);
    castout_valid = 1'b0;
  endtask
  task automatic t_fill();
    transfer_ack = 1'b1;
    fill_last_ack = 1'b1;
    snp(TT_KILL, A, 0, 0, 0, MEI_E, 1, 0, MEI_I, 0, 0, 0, 0);
    data_retry_en = 1'b1;
    @(negedge clk);
    transfer_ack = 1'b0;
    fill_last_ack = 1'b0;
    snp(TT_KILL, A, 0, 0, 0, MEI_E, 1, 0, MEI_I, 0, 0, 0, 0);
    data_retry_en = 1'b0;
  endtask
  task automatic t_ops();
    for (int k = 0; k < 3; k++)
    begin
      {op_first, op_last, blk_tag_upd} = 3'h4 >> k;
      snp(TT_KILL, B, 0, 0, 0, MEI_E, 1, 0, MEI_I, 0, 0, 0, 0);
    end
    {op_first, op_last, blk_tag_upd} = 3'h0;
  endtask
  task automatic t_burst();
    burst_load = 1'b1;
    transfer_ack = 1'b1;
    @(negedge clk);
    transfer_ack = 1'b0;
    snp(TT_KILL, A, 0, 0, 0, MEI_E, 1, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_KILL, B, 0, 0, 0, MEI_I, 0, 0, MEI_I, 0, 0, 0, 0);
    burst_load = 1'b0;
  endtask
  task automatic t_own_read();
    rd_addr = A;
    rd_addr_done = 1'b1;
    @(negedge clk);
    rd_addr_done = 1'b0;
    @(negedge clk);
    snp(TT_KILL, A, 0, 0, 0, MEI_M, 1, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_KILL, A, 0, 0, 0, MEI_I, 1, 0, MEI_I, 0, 0, 0, 0);
    snp(TT_KILL, B, 0, 0, 0, MEI_M, 0, 1, MEI_I, 1, 1, 1, 1);
    rd_data_done = 1'b1;
    @(negedge clk);
    rd_data_done = 1'b0;
    @(negedge clk);
    snp(TT_KILL, A, 0, 0, 0, MEI_M, 0, 1, MEI_I, 1, 1, 1, 0);
  endtask
  task automatic t_req();
    dcsr_req_t kinds [3] = '{REQ_ZERO_GLOBAL, REQ_LOAD_RESV, REQ_STORE_COND};
    logic [4:0] tts [3] = '{TT_KILL, TT_READ_ATOMIC, TT_READ_INTENT_MODIFY_ATOMIC};
    for (int k = 0; k < 3; k++)
    begin
      req_valid = 1'b1;
      req_kind = kinds[k];
      req_addr = A + 32'h20 * k;
      @(negedge clk);
      chk_req({bus_req_valid, bus_req_tt, bus_req_addr, bus_req_addr_only}, {1'b1, tts[k], req_addr, k == 0});
    end
    req_valid = 1'b0;
  endtask
  task automatic t_grant();
    store_pipelined = 1'b1;
    far.grant(1'b1, 1'b1);
    @(negedge clk);
    far.grant(1'b1, 1'b0);
    chk_ten({tenure_store, tenure_load}, 2'h2);
    @(negedge clk);
    far.grant(1'b0, 1'b0);
    chk_ten({tenure_store, tenure_load}, 2'h1);
    store_pipelined = 1'b0;
  endtask
  initial
  begin
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    t_table();
    t_castout();
    t_fill();
    t_ops();
    t_burst();
    t_own_read();
    t_req();
    t_grant();
    report_and_stop();
  end
endmodule
`default_nettype wire
